// >>> logic/apt_irq_top.sv
// Alarm and periodic timer interrupt block with its register file.
// Assumes a host on a plain strobe bus and a same-clock time-keeping core.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module apt_irq_top #(
    parameter longint ALARM_LAT_LIMIT = apt_pkg::ALARM_LAT_CYC
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Register port.
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // Time base.
    input wire apt_pkg::apt_ticks_t ticks,
    input wire logic minuteUpdate,
    input wire apt_pkg::apt_time_t now,
    // First interrupt pin, open drain.
    output logic interruptOutFirst,
    output logic interruptOutFirstOe,
    // Periodic timer status.
    output logic periodicEvent
);
    import apt_pkg::*;

    logic [7:0] alarmMin_r;
    logic [7:0] alarmHour_r;
    logic [7:0] alarmDay_r;
    logic [15:0] preset_r;
    logic [7:0] ext_r;
    logic [7:0] ctrl_r;
    logic alarmFlag_r;
    logic alarmFlag_nxt;
    logic periodicFlag_r;
    logic periodicFlag_nxt;
    logic timerRunPrev_r;
    logic irqOe_r;
    logic [7:0] rdData_r;
    logic [7:0] rdMux;
    logic wrAlarmMin;
    logic wrAlarmHour;
    logic wrAlarmDay;
    logic wrFlags;
    logic timerRun;
    logic timerLoad;
    logic timerGo;
    logic srcTick;
    logic [15:0] timerCount;
    logic timerExpired;
    logic alarmMatch;
    logic alarmEvent;
    logic stopBit;
    apt_src_t src;

    assign wrAlarmMin = regWrite && regAddr == ADDR_ALARM_MIN;
    assign wrAlarmHour = regWrite && regAddr == ADDR_ALARM_HOUR;
    assign wrAlarmDay = regWrite && regAddr == ADDR_ALARM_DAY;
    assign wrFlags = regWrite && regAddr == ADDR_FLAGS;
    assign stopBit = ctrl_r[CTRL_STOP_BIT];
    assign timerRun = ext_r[EXT_TIMER_RUN_BIT];
    assign src = apt_src_t'(ext_r[2:0]);

    // Alarm settings, also usable as plain storage.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            alarmMin_r <= ALARM_RESET;
            alarmHour_r <= ALARM_RESET;
            alarmDay_r <= ALARM_RESET;
        end
        else
        begin
            if (wrAlarmMin)
            begin
                alarmMin_r <= regWrData;
            end
            if (wrAlarmHour)
            begin
                alarmHour_r <= regWrData;
            end
            if (wrAlarmDay)
            begin
                alarmDay_r <= regWrData;
            end
        end
    end

    // Timer preset, extension and control settings.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            preset_r <= PRESET_RESET;
            ext_r <= EXT_RESET;
            ctrl_r <= CTRL_RESET;
        end
        else if (regWrite)
        begin
            unique case (regAddr)
                ADDR_PRESET_LO: preset_r[7:0] <= regWrData;
                ADDR_PRESET_HI: preset_r[15:8] <= regWrData;
                ADDR_EXT: ext_r <= regWrData & EXT_WMASK;
                ADDR_CTRL: ctrl_r <= regWrData & CTRL_WMASK;
                default: ;
            endcase
        end
    end

    // Tick source selection; a stop halts all but the fastest source.
    always_comb
    begin
        unique case (src)
            SRC_4096HZ: srcTick = ticks.hz4096;
            SRC_64HZ: srcTick = ticks.hz64;
            SRC_1HZ: srcTick = ticks.hz1;
            SRC_MINUTE: srcTick = ticks.minute;
            SRC_HOUR: srcTick = ticks.hour;
            default: srcTick = 1'b0;
        endcase
    end

    assign timerGo = timerRun && !ctrl_r[CTRL_TIMER_STOP_BIT] && !(stopBit && src != SRC_4096HZ);

    // Detects the timer run bit going from zero to one.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            timerRunPrev_r <= 1'b0;
        end
        else
        begin
            timerRunPrev_r <= timerRun;
        end
    end

    assign timerLoad = timerRun && !timerRunPrev_r;

    apt_down_counter timerCounter (
        .core_clk(core_clk),
        .reset(reset),
        .load(timerLoad),
        .run(timerGo),
        .tick(srcTick),
        .preset(preset_r),
        .count(timerCount),
        .expired(timerExpired)
    );

    apt_alarm_match alarmCompare (
        .core_clk(core_clk),
        .reset(reset),
        .minuteUpdate(minuteUpdate),
        .now(now),
        .alarmMin(alarmMin_r),
        .alarmHour(alarmHour_r),
        .alarmDay(alarmDay_r),
        .weekOrDateSelect(ext_r[EXT_WEEK_DATE_BIT]),
        .match(alarmMatch)
    );

    assign alarmEvent = alarmMatch && !stopBit;

    // Flags: an event in the clearing cycle wins over the clear.
    always_comb
    begin
        alarmFlag_nxt = alarmFlag_r;
        if (alarmEvent)
        begin
            alarmFlag_nxt = 1'b1;
        end
        else if (wrFlags && !regWrData[FLAG_ALARM_BIT])
        begin
            alarmFlag_nxt = 1'b0;
        end
        periodicFlag_nxt = periodicFlag_r;
        if (timerExpired)
        begin
            periodicFlag_nxt = 1'b1;
        end
        else if (wrFlags && !regWrData[FLAG_PERIODIC_BIT])
        begin
            periodicFlag_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            alarmFlag_r <= 1'b0;
            periodicFlag_r <= 1'b0;
        end
        else
        begin
            alarmFlag_r <= alarmFlag_nxt;
            periodicFlag_r <= periodicFlag_nxt;
        end
    end

    // The enable gates only the pin; the low level holds while the flag stands.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            irqOe_r <= 1'b0;
        end
        else
        begin
            irqOe_r <= alarmFlag_r && ctrl_r[CTRL_ALARM_IE_BIT];
        end
    end

    assign interruptOutFirst = 1'b0;
    assign interruptOutFirstOe = irqOe_r;
    assign periodicEvent = timerExpired;

    // Read mux; the timer registers show the live count while running.
    always_comb
    begin
        unique case (regAddr)
            ADDR_ALARM_MIN: rdMux = alarmMin_r;
            ADDR_ALARM_HOUR: rdMux = alarmHour_r;
            ADDR_ALARM_DAY: rdMux = alarmDay_r;
            ADDR_PRESET_LO: rdMux = timerRun ? timerCount[7:0] : preset_r[7:0];
            ADDR_PRESET_HI: rdMux = timerRun ? timerCount[15:8] : preset_r[15:8];
            ADDR_EXT: rdMux = ext_r;
            ADDR_FLAGS: rdMux = {3'h0, periodicFlag_r, alarmFlag_r, 3'h0};
            ADDR_CTRL: rdMux = ctrl_r;
            default: rdMux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rdData_r <= 8'h00;
        end
        else
        begin
            rdData_r <= regRead ? rdMux : 8'h00;
        end
    end

    assign regRdData = rdData_r;

    // Helper: cycles since a match with the flag still low.
    logic [31:0] latCnt_r;
    always_ff @(posedge core_clk)
    begin
        if (reset || alarmFlag_r || (!stopBit && alarmMatch == 1'b0 && latCnt_r == 32'h0))
        begin
            latCnt_r <= 32'h0;
        end
        else if (alarmEvent || latCnt_r != 32'h0)
        begin
            latCnt_r <= latCnt_r + 32'h1;
        end
    end

    alarmLatency_a: assert property (@(posedge core_clk) disable iff (reset)
        latCnt_r <= 32'(ALARM_LAT_LIMIT))
        else $error("Alarm flag late after match.");

    alarmSets_a: assert property (@(posedge core_clk) disable iff (reset)
        alarmEvent |=> alarmFlag_r)
        else $error("Alarm event did not set flag.");

    alarmPin_a: assert property (@(posedge core_clk) disable iff (reset)
        alarmEvent && ctrl_r[CTRL_ALARM_IE_BIT] && !regWrite |-> ##2 interruptOutFirstOe)
        else $error("Enabled alarm did not pull the pin.");

    alarmHold_a: assert property (@(posedge core_clk) disable iff (reset)
        alarmFlag_r && !(wrFlags && !regWrData[FLAG_ALARM_BIT]) |=> alarmFlag_r)
        else $error("Alarm flag dropped without a clear.");

    alarmClear_a: assert property (@(posedge core_clk) disable iff (reset)
        wrFlags && !regWrData[FLAG_ALARM_BIT] && !alarmEvent |=> ##1 !interruptOutFirstOe)
        else $error("Clearing the flag did not release the pin.");

    stopBlocks_a: assert property (@(posedge core_clk) disable iff (reset)
        stopBit && !alarmFlag_r && !(regWrite && regAddr == ADDR_CTRL) |=> !alarmFlag_r)
        else $error("Alarm flag set while clock stopped.");

    enableOnly_a: assert property (@(posedge core_clk) disable iff (reset)
        regWrite && regAddr == ADDR_CTRL && alarmFlag_r && !wrFlags |=> alarmFlag_r)
        else $error("Control write changed the alarm flag.");

    timerFlag_a: assert property (@(posedge core_clk) disable iff (reset)
        timerExpired |=> periodicFlag_r)
        else $error("Timer event did not set periodic flag.");

    timerRestart_a: assert property (@(posedge core_clk) disable iff (reset)
        timerLoad |=> timerCount == $past(preset_r))
        else $error("Timer did not restart from preset.");

    pinDrivesLow_a: assert property (@(posedge core_clk) disable iff (reset)
        interruptOutFirstOe |-> interruptOutFirst == 1'b0 && $past(alarmFlag_r))
        else $error("Open-drain pin driven without a standing alarm.");

    alarmFired_c: cover property (@(posedge core_clk) disable iff (reset)
        alarmEvent ##2 interruptOutFirstOe);
    timerFired_c: cover property (@(posedge core_clk) disable iff (reset)
        timerExpired ##1 periodicFlag_r);
    flagCleared_c: cover property (@(posedge core_clk) disable iff (reset)
        alarmFlag_r ##1 !alarmFlag_r);
endmodule : apt_irq_top

// >>> logic/apt_pkg.sv
// Shared constants and carrier types for the alarm and periodic timer block.
// Assumes a single 40 MHz core clock and a same-clock time-keeping core.
package apt_pkg;
    // Register offsets.
    localparam logic [7:0] ADDR_ALARM_MIN = 8'h18;
    localparam logic [7:0] ADDR_ALARM_HOUR = 8'h19;
    localparam logic [7:0] ADDR_ALARM_DAY = 8'h1A;
    localparam logic [7:0] ADDR_PRESET_LO = 8'h1B;
    localparam logic [7:0] ADDR_PRESET_HI = 8'h1C;
    localparam logic [7:0] ADDR_EXT = 8'h1D;
    localparam logic [7:0] ADDR_FLAGS = 8'h1E;
    localparam logic [7:0] ADDR_CTRL = 8'h1F;
    // Field positions.
    localparam int CMP_DIS_BIT = 7;
    localparam int EXT_TIMER_RUN_BIT = 4;
    localparam int EXT_WEEK_DATE_BIT = 3;
    localparam int FLAG_PERIODIC_BIT = 4;
    localparam int FLAG_ALARM_BIT = 3;
    localparam int CTRL_STOP_BIT = 6;
    localparam int CTRL_ALARM_IE_BIT = 3;
    localparam int CTRL_TIMER_STOP_BIT = 2;
    // Reset values.
    localparam logic [7:0] ALARM_RESET = 8'h80;
    localparam logic [7:0] EXT_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] PRESET_RESET = 16'h0000;
    // Writable bit masks.
    localparam logic [7:0] EXT_WMASK = 8'hFF;
    localparam logic [7:0] CTRL_WMASK = 8'hFC;
    // Timing: alarm flag must follow a match within this time.
    localparam longint CLK_HZ = 40000000;
    localparam longint ALARM_LAT_NS = 1460000;
    localparam longint ALARM_LAT_CYC = (ALARM_LAT_NS * CLK_HZ) / 1000000000;

    typedef enum logic [2:0] {
        SRC_4096HZ = 3'b000,
        SRC_64HZ = 3'b001,
        SRC_1HZ = 3'b010,
        SRC_MINUTE = 3'b011,
        SRC_HOUR = 3'b100
    } apt_src_t;

    // Present time from the time-keeping core, in BCD except the weekday, which has one bit per day.
    typedef struct packed {
        logic [6:0] minute;
        logic [5:0] hour;
        logic [6:0] weekday;
        logic [5:0] date;
    } apt_time_t;

    // One-cycle tick pulses from the time base.
    typedef struct packed {
        logic hz4096;
        logic hz64;
        logic hz1;
        logic minute;
        logic hour;
    } apt_ticks_t;
endpackage : apt_pkg

// >>> logic/apt_down_counter.sv
// Sixteen-bit reloading down counter for the periodic timer.
// Assumes tick is a one-cycle pulse on core_clk.
`timescale 1ns/1ps
module apt_down_counter (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Control.
    input wire logic load,
    input wire logic run,
    input wire logic tick,
    input wire logic [15:0] preset,
    // Status.
    output logic [15:0] count,
    output logic expired
);
    import apt_pkg::*;

    // Counts down on ticks, restarts from the preset on load or after expiry.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            count <= PRESET_RESET;
        end
        else if (load)
        begin
            count <= preset;
        end
        else if (run && tick && count != 16'h0000)
        begin
            if (count == 16'h0001)
            begin
                count <= preset;
            end
            else
            begin
                count <= count - 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            expired <= 1'b0;
        end
        else
        begin
            expired <= !load && run && tick && count == 16'h0001;
        end
    end

    reloadAfterExpiry_a: assert property (@(posedge core_clk) disable iff (reset)
        expired |-> count == $past(preset))
        else $error("Counter did not reload after expiry.");
endmodule : apt_down_counter

// >>> logic/apt_alarm_match.sv
// Alarm comparator, evaluated once per minute update of the time counters.
// Assumes minuteUpdate pulses in the cycle after the counters advance.
`timescale 1ns/1ps
module apt_alarm_match (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Time and settings.
    input wire logic minuteUpdate,
    input wire apt_pkg::apt_time_t now,
    input wire logic [7:0] alarmMin,
    input wire logic [7:0] alarmHour,
    input wire logic [7:0] alarmDay,
    input wire logic weekOrDateSelect,
    // Result.
    output logic match
);
    import apt_pkg::*;

    logic minOk;
    logic hourOk;
    logic dayOk;

    // A field with its compare-disable bit set is left out of the match.
    always_comb
    begin
        minOk = alarmMin[CMP_DIS_BIT] || now.minute == alarmMin[6:0];
        hourOk = alarmHour[CMP_DIS_BIT] || now.hour == alarmHour[5:0];
        if (alarmDay[CMP_DIS_BIT])
        begin
            dayOk = 1'b1;
        end
        else if (weekOrDateSelect)
        begin
            dayOk = now.date == alarmDay[5:0];
        end
        else
        begin
            dayOk = |(now.weekday & alarmDay[6:0]);
        end
    end

    // Only the minute update can start a match, so present time never fires at once.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            match <= 1'b0;
        end
        else
        begin
            match <= minuteUpdate && minOk && hourOk && dayOk;
        end
    end

    matchOnUpdate_a: assert property (@(posedge core_clk) disable iff (reset)
        match |-> $past(minuteUpdate))
        else $error("Alarm match outside a minute update.");
endmodule : apt_alarm_match

// >>> dv/apt_time_model.sv
// Behavioural time-keeping core that feeds the alarm and periodic timer block.
// Assumes the bench asks for minute steps and tick pulses on core_clk.
`timescale 1ns/1ps
module apt_time_model
    import apt_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Requests from the bench.
    input wire logic stepReq,
    input wire apt_pkg::apt_time_t stepTime,
    input wire apt_pkg::apt_ticks_t tickReq,
    // Time base outputs.
    output apt_pkg::apt_time_t now,
    output logic minuteUpdate,
    output apt_pkg::apt_ticks_t ticks
);
    // The counters advance only on a step, and the update pulse shows with the new value.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            now <= '0;
            minuteUpdate <= 1'b0;
        end
        else
        begin
            minuteUpdate <= stepReq;
            if (stepReq)
            begin
                now <= stepTime;
            end
        end
    end

    // Each requested tick becomes a pulse of one cycle.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ticks <= '0;
        end
        else
        begin
            ticks <= tickReq;
        end
    end
endmodule : apt_time_model

// >>> dv/apt_tb.sv
// Self-checking bench for the alarm and periodic timer block.
// Assumes the time model drives the time base and the bench acts as host.
`timescale 1ns/1ps
module tb;
    import apt_pkg::*;
    localparam logic [7:0] RST_ADDR [9] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20};
    localparam logic [7:0] RST_VAL [9] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] RW_ADDR [5] = '{8'h18, 8'h19, 8'h1A, 8'h1D, 8'h1F};
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regRdData;
    logic stepReq = 1'b0;
    apt_time_t stepTime = '0;
    apt_ticks_t tickReq = '0;
    apt_ticks_t ticks;
    apt_time_t now;
    logic minuteUpdate;
    logic irqOut;
    logic irqOe;
    logic periodicEvent;
    logic irqPin;
    logic [7:0] rdVal;
    int errorCnt = 0;
    int nChecks = 0;
    int evCnt = 0;

    // The pin has a pull-up, so it is high unless the block drives it.
    assign irqPin = irqOe ? irqOut : 1'b1;

    always #12.5 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        if (periodicEvent === 1'b1)
            evCnt++;
    end

    apt_irq_top #(.ALARM_LAT_LIMIT(10)) dut (.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .ticks(ticks), .minuteUpdate(minuteUpdate), .now(now), .interruptOutFirst(irqOut),
        .interruptOutFirstOe(irqOe), .periodicEvent(periodicEvent));

    apt_time_model tbase (.core_clk(core_clk), .reset(reset), .stepReq(stepReq), .stepTime(stepTime),
        .tickReq(tickReq), .now(now), .minuteUpdate(minuteUpdate), .ticks(ticks));

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        nChecks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk1

    task automatic wrapUp();
        $display("comparisons %0d, mismatches %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrapUp

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        rdVal = regRdData;
    endtask : rd

    task automatic settle();
        repeat (3) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic step(input apt_time_t t);
        @(posedge core_clk);
        stepTime <= t;
        stepReq <= 1'b1;
        @(posedge core_clk);
        stepReq <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask : step

    task automatic tick(input int src);
        @(posedge core_clk);
        tickReq <= apt_ticks_t'(5'h10 >> src);
        @(posedge core_clk);
        tickReq <= '0;
        repeat (3) @(posedge core_clk);
    endtask : tick

    function automatic logic [7:0] bcd(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction : bcd

    function automatic apt_time_t randTime();
        apt_time_t t;
        t.minute = 7'(bcd($urandom % 60));
        t.hour = 6'(bcd($urandom % 24));
        t.weekday = 7'h01 << ($urandom % 7);
        t.date = 6'(bcd(1 + $urandom % 31));
        return t;
    endfunction : randTime

    function automatic logic expMatch(input apt_time_t t, input logic [7:0] m, input logic [7:0] h,
        input logic [7:0] d, input logic wd);
        logic ok;
        ok = m[7] || (m[6:0] == t.minute);
        ok = ok && (h[7] || (h[5:0] == t.hour));
        if (!d[7])
            ok = ok && (wd ? (d[5:0] == t.date) : ((d[6:0] & t.weekday) != 7'h00));
        return ok;
    endfunction : expMatch

    initial
    begin
        repeat (100000) @(posedge core_clk);
        errorCnt++;
        $display("run cut short by the watchdog");
        wrapUp();
    end

    initial
    begin
        apt_time_t t;
        apt_time_t u;
        logic [7:0] m;
        logic [7:0] h;
        logic [7:0] d;
        logic [7:0] v;
        logic wd;
        logic stop;
        logic exp;
        int p;
        int base;
        void'($urandom(67538));
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        for (int k = 0; k < 9; k++)
        begin
            rd(RST_ADDR[k]);
            chk8(rdVal, RST_VAL[k]);
        end
        for (int k = 0; k < 5; k++)
        begin
            v = 8'($urandom);
            v = (k == 1) ? (v & 8'hBF) : v;
            wr(RW_ADDR[k], v);
            rd(RW_ADDR[k]);
            chk8(rdVal, (k == 4) ? (v & 8'hFC) : v);
        end
        wr(8'h20, 8'($urandom));
        rd(8'h20);
        chk8(rdVal, 8'h00);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_EXT, 8'h00);
        $display("register test done");
        for (int s = 0; s < 5; s++)
        begin
            p = 2 + $urandom % 4;
            wr(ADDR_EXT, 8'(s));
            wr(ADDR_PRESET_LO, 8'(p));
            wr(ADDR_PRESET_HI, 8'h00);
            wr(ADDR_FLAGS, 8'h00);
            wr(ADDR_EXT, 8'(s) | 8'h10);
            base = evCnt;
            repeat (p - 1) tick(s);
            tick((s + 1) % 5);
            chk8(8'(evCnt - base), 8'h00);
            tick(s);
            chk8(8'(evCnt - base), 8'h01);
            rd(ADDR_FLAGS);
            chk1(rdVal[FLAG_PERIODIC_BIT], 1'b1);
            repeat (p) tick(s);
            chk8(8'(evCnt - base), 8'h02);
            repeat (p - 1) tick(s);
            wr(ADDR_EXT, 8'(s));
            wr(ADDR_EXT, 8'(s) | 8'h10);
            repeat (p - 1) tick(s);
            chk8(8'(evCnt - base), 8'h02);
            wr(ADDR_CTRL, (s == 0) ? 8'h04 : 8'h40);
            tick(s);
            wr(ADDR_CTRL, 8'h00);
            chk8(8'(evCnt - base), 8'h02);
            tick(s);
            chk8(8'(evCnt - base), 8'h03);
            wr(ADDR_FLAGS, 8'h00);
            rd(ADDR_FLAGS);
            chk1(rdVal[FLAG_PERIODIC_BIT], 1'b0);
            wr(ADDR_EXT, 8'h00);
            $display("timer test source %0d preset %0d done", s, p);
        end
        for (int i = 0; i < 40; i++)
        begin
            t = randTime();
            u = randTime();
            wd = 1'($urandom % 2);
            stop = ($urandom % 5 == 0);
            m = {($urandom % 4 == 0) || (i < 2), ($urandom % 4 != 0) ? t.minute : u.minute};
            h = {($urandom % 4 == 0) || (i < 2), 1'b0, ($urandom % 4 != 0) ? t.hour : u.hour};
            d[6:0] = wd ? {1'b0, ($urandom % 4 != 0) ? t.date : u.date}
                : ((($urandom % 4 != 0) ? t.weekday : 7'h00) | u.weekday);
            d[7] = ($urandom % 4 == 0) || (i < 2);
            wr(ADDR_CTRL, 8'h00);
            wr(ADDR_FLAGS, 8'h00);
            wr(ADDR_ALARM_MIN, m);
            wr(ADDR_ALARM_HOUR, h);
            wr(ADDR_ALARM_DAY, d);
            wr(ADDR_EXT, {4'h0, wd, 3'h0});
            wr(ADDR_CTRL, {1'b0, stop, 6'h08});
            step(t);
            exp = expMatch(t, m, h, d, wd) && !stop;
            rd(ADDR_FLAGS);
            chk1(rdVal[FLAG_ALARM_BIT], exp);
            chk1(irqPin, !exp);
        end
        $display("random alarm test done");
        t = now;
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_ALARM_MIN, {1'b0, t.minute});
        wr(ADDR_ALARM_HOUR, {2'b00, t.hour});
        wr(ADDR_ALARM_DAY, 8'h80);
        wr(ADDR_EXT, 8'h00);
        wr(ADDR_FLAGS, 8'h00);
        wr(ADDR_CTRL, 8'h08);
        repeat (20) @(posedge core_clk);
        rd(ADDR_FLAGS);
        chk8(rdVal, 8'h00);
        step(t);
        repeat (200) @(posedge core_clk);
        chk1(irqPin, 1'b0);
        wr(ADDR_FLAGS, 8'h08);
        rd(ADDR_FLAGS);
        chk8(rdVal, 8'h08);
        chk1(irqPin, 1'b0);
        wr(ADDR_FLAGS, 8'h00);
        settle();
        chk1(irqPin, 1'b1);
        rd(ADDR_FLAGS);
        chk8(rdVal, 8'h00);
        step(t);
        wr(ADDR_CTRL, 8'h00);
        settle();
        chk1(irqPin, 1'b1);
        rd(ADDR_FLAGS);
        chk8(rdVal, 8'h08);
        wr(ADDR_FLAGS, 8'h00);
        rd(ADDR_FLAGS);
        chk8(rdVal, 8'h00);
        $display("alarm hold and release test done");
        wrapUp();
    end
endmodule : tb
